/* vcd_top.sv */
// Purpose: Video capture path with start offsets, byte and line decimation,
//          line stride addressing and a host-fed output FIFO.
// Assumes: AHB-Lite slave on hclk; pixel port sampled through two flops.
// Notes: Source changes data away from the rising pixel clock edge.
//
// Functional notes
// - A 12-bit horizontal start holds pixel clocks from line sync to first pixel minus two.
// - A 9-bit vertical start gives the line syncs after frame sync before the first line.
// - Start offsets apply only in 8-bit and 16-bit video modes, never in pass-through.
// - Each group of 32 byte positions is checked against a byte mask; a set bit discards.
// - One byte-mask bit covers two bytes in 16-bit mode and four bytes in pass-through.
// - Byte masking restarts at bit zero after each line sync, aligned after the offset.
// - Each group of 32 lines is checked against a line mask; a clear bit discards.
// - Line mask counting starts at the frame sync, not after the vertical offset.
// - Each line sync after the first of a frame adds the 12-bit byte stride to the current line start address.
// - A word-size write to any of eight words from ff40 to ff5c pushes one FIFO entry unless the FIFO is full.
// - The line mask clears to zero at power-on.
// - Each word leaving the output FIFO is tagged with transaction type 110.
`timescale 1ns/1ps
module vcd_top
    import vcd_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Video input pins
    input wire logic port_pixel_clock,
    input wire logic vid_hsync,
    input wire logic vid_vsync,
    input wire logic [31:0] vid_data,
    // Frame buffer write port
    output logic cap_valid,
    output logic [21:0] cap_addr,
    output logic [31:0] cap_data,
    output logic [2:0] cap_nbytes,
    // Output FIFO drain to peripheral port
    output logic ofifo_valid,
    input wire logic ofifo_ready,
    output logic [31:0] ofifo_data,
    output logic [2:0] ofifo_transaction_type
);

    // ==========================================
    // Helpers
    function automatic logic is_video(input logic [1:0] m);
        is_video = (m == VCD_MODE_V8) || (m == VCD_MODE_V16);
    endfunction

    function automatic logic [2:0] unit_bytes(input logic [1:0] m);
        unique case (m)
            VCD_MODE_V8: unit_bytes = 3'h1;
            VCD_MODE_V16: unit_bytes = 3'h2;
            default: unit_bytes = 3'h4;
        endcase
    endfunction

    // ==========================================
    // Bus and register bank
    logic wr_pend_r, wr_pend_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [31:0] start_r, start_nxt;
    logic [31:0] hmask_r, hmask_nxt;
    logic [31:0] vmask_r, vmask_nxt;
    logic [VCD_STRIDE_W-1:0] stride_r, stride_nxt;
    logic [VCD_FB_W-1:0] fb0_r, fb0_nxt;
    logic [VCD_FB_W-1:0] fb1_r, fb1_nxt;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic push;
    logic [VCD_FIFO_CW-1:0] free_cnt;
    logic [1:0] mode;
    logic [VCD_HSTART_W-1:0] hstart;
    logic [VCD_VSTART_W-1:0] vstart;
    assign mode = ctrl_r[VCD_CTRL_MODE_LSB +: 2];
    assign hstart = start_r[VCD_HSTART_LSB +: VCD_HSTART_W];
    assign vstart = start_r[VCD_VSTART_LSB +: VCD_VSTART_W];
    always_comb begin
        wr_pend_nxt = 1'b0;
        addr_nxt = addr_r;
        start_nxt = start_r;
        hmask_nxt = hmask_r;
        vmask_nxt = vmask_r;
        stride_nxt = stride_r;
        fb0_nxt = fb0_r;
        fb1_nxt = fb1_r;
        ctrl_nxt = ctrl_r;
        push = 1'b0;
        if (wr_pend_r) begin
            unique case (addr_r)
                VCD_OFS_START: start_nxt = hwdata;
                VCD_OFS_HMASK: hmask_nxt = hwdata;
                VCD_OFS_VMASK: vmask_nxt = hwdata;
                VCD_OFS_STRIDE: stride_nxt = hwdata[VCD_STRIDE_W-1:0];
                VCD_OFS_FB0: fb0_nxt = hwdata[VCD_FB_W-1:0];
                VCD_OFS_FB1: fb1_nxt = hwdata[VCD_FB_W-1:0];
                VCD_OFS_CTRL: ctrl_nxt = hwdata;
                default: push = (addr_r >= VCD_OFS_WIN_LO) && (addr_r <= VCD_OFS_WIN_HI);
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            addr_nxt = {haddr[15:2], 2'b00};
            wr_pend_nxt = hwrite && (hsize == VCD_HSIZE_WORD);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= 16'h0000;
            start_r <= VCD_RST_WORD;
            hmask_r <= VCD_RST_WORD;
            vmask_r <= VCD_RST_WORD;
            stride_r <= VCD_RST_WORD[VCD_STRIDE_W-1:0];
            fb0_r <= VCD_RST_WORD[VCD_FB_W-1:0];
            fb1_r <= VCD_RST_WORD[VCD_FB_W-1:0];
            ctrl_r <= VCD_RST_WORD;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            addr_r <= addr_nxt;
            start_r <= start_nxt;
            hmask_r <= hmask_nxt;
            vmask_r <= vmask_nxt;
            stride_r <= stride_nxt;
            fb0_r <= fb0_nxt;
            fb1_r <= fb1_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // Read mux reflects the register addressed in the data phase
    always_comb begin
        unique case (addr_r)
            VCD_OFS_FIFO_STAT: hrdata = {28'h0000000, free_cnt};
            VCD_OFS_START: hrdata = start_r & 32'h01ff_0fff;
            VCD_OFS_HMASK: hrdata = hmask_r;
            VCD_OFS_VMASK: hrdata = vmask_r;
            VCD_OFS_STRIDE: hrdata = {20'h00000, stride_r};
            VCD_OFS_FB0: hrdata = {10'h000, fb0_r};
            VCD_OFS_FB1: hrdata = {10'h000, fb1_r};
            VCD_OFS_CTRL: hrdata = ctrl_r & 32'h0000_0113;
            default: hrdata = 32'h0000_0000;
        endcase
    end

    assign hreadyout = 1'b1;
    assign hresp = VCD_HRESP_OKAY;

    // ==========================================
    // Pixel port synchroniser
    logic [34:0] pin_s1_r, pin_s2_r;
    logic pclk_d_r, hs_d_r, vs_d_r;
    logic pclk_s, hs_s, vs_s;
    logic [31:0] data_s;
    logic pix_edge, hs_rise, vs_rise;
    assign pclk_s = pin_s2_r[34];
    assign hs_s = pin_s2_r[33];
    assign vs_s = pin_s2_r[32];
    assign data_s = pin_s2_r[31:0];
    assign pix_edge = pclk_s && !pclk_d_r;
    assign hs_rise = pix_edge && hs_s && !hs_d_r;
    assign vs_rise = pix_edge && vs_s && !vs_d_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= 35'h0;
            pin_s2_r <= 35'h0;
            pclk_d_r <= 1'b0;
            hs_d_r <= 1'b0;
            vs_d_r <= 1'b0;
        end else begin
            pin_s1_r <= {port_pixel_clock, vid_hsync, vid_vsync, vid_data};
            pin_s2_r <= pin_s1_r;
            pclk_d_r <= pclk_s;
            if (pix_edge) begin
                hs_d_r <= hs_s;
                vs_d_r <= vs_s;
            end
        end
    end

    // ==========================================
    // Capture and decimation
    logic [VCD_LINE_W-1:0] line_cnt_r, line_cnt_nxt;
    logic [VCD_HCNT_W-1:0] hcnt_r, hcnt_nxt;
    logic [4:0] hidx_r, hidx_nxt;
    logic [VCD_FB_W-1:0] line_start_r, line_start_nxt;
    logic [VCD_FB_W-1:0] offs_r, offs_nxt;
    logic cap_valid_r, cap_valid_nxt;
    logic [21:0] cap_addr_r, cap_addr_nxt;
    logic [31:0] cap_data_r, cap_data_nxt;
    logic [2:0] cap_nbytes_r, cap_nbytes_nxt;
    logic [VCD_LINE_W-1:0] line_idx;
    logic line_keep, h_ok;
    assign line_idx = line_cnt_r - {{(VCD_LINE_W-1){1'b0}}, 1'b1};
    // Mask position counts from frame sync and wraps through 5 bits
    assign line_keep = (line_cnt_r != '0) && vmask_r[line_idx[4:0]]
        && (!is_video(mode) || line_cnt_r > {1'b0, vstart})
        && ctrl_r[VCD_CTRL_EN_BIT];
    assign h_ok = !is_video(mode) || hcnt_r >= ({1'b0, hstart} + VCD_H_BIAS);
    always_comb begin
        line_cnt_nxt = line_cnt_r;
        hcnt_nxt = hcnt_r;
        hidx_nxt = hidx_r;
        line_start_nxt = line_start_r;
        offs_nxt = offs_r;
        cap_valid_nxt = 1'b0;
        cap_addr_nxt = cap_addr_r;
        cap_data_nxt = cap_data_r;
        cap_nbytes_nxt = cap_nbytes_r;
        if (vs_rise) begin
            line_cnt_nxt = '0;
            line_start_nxt = ctrl_r[VCD_CTRL_BUF_BIT] ? fb1_r : fb0_r;
            hcnt_nxt = '0;
            hidx_nxt = 5'h00;
            offs_nxt = '0;
        end else if (hs_rise) begin
            if (line_cnt_r != {VCD_LINE_W{1'b1}}) begin
                line_cnt_nxt = line_cnt_r + {{(VCD_LINE_W-1){1'b0}}, 1'b1};
            end
            if (line_cnt_r != '0) begin
                line_start_nxt = line_start_r + {10'h000, stride_r};
            end
            // Sync clock is clock zero, the next one clock one
            hcnt_nxt = {{(VCD_HCNT_W-1){1'b0}}, 1'b1};
            hidx_nxt = 5'h00;
            offs_nxt = '0;
        end else if (pix_edge) begin
            if (!h_ok) begin
                hcnt_nxt = hcnt_r + {{(VCD_HCNT_W-1){1'b0}}, 1'b1};
            end else begin
                hidx_nxt = hidx_r + 5'h01;
                if (line_keep && !hmask_r[hidx_r]) begin
                    cap_valid_nxt = 1'b1;
                    cap_addr_nxt = line_start_r + offs_r;
                    cap_data_nxt = data_s;
                    cap_nbytes_nxt = unit_bytes(mode);
                    offs_nxt = offs_r + {19'h00000, unit_bytes(mode)};
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_cnt_r <= '0;
            hcnt_r <= '0;
            hidx_r <= 5'h00;
            line_start_r <= '0;
            offs_r <= '0;
            cap_valid_r <= 1'b0;
            cap_addr_r <= 22'h000000;
            cap_data_r <= 32'h0000_0000;
            cap_nbytes_r <= 3'h0;
        end else begin
            line_cnt_r <= line_cnt_nxt;
            hcnt_r <= hcnt_nxt;
            hidx_r <= hidx_nxt;
            line_start_r <= line_start_nxt;
            offs_r <= offs_nxt;
            cap_valid_r <= cap_valid_nxt;
            cap_addr_r <= cap_addr_nxt;
            cap_data_r <= cap_data_nxt;
            cap_nbytes_r <= cap_nbytes_nxt;
        end
    end

    assign cap_valid = cap_valid_r;
    assign cap_addr = cap_addr_r;
    assign cap_data = cap_data_r;
    assign cap_nbytes = cap_nbytes_r;

    // ==========================================
    // Output FIFO
    logic [31:0] fifo_mem_r [VCD_FIFO_DEPTH];
    logic [31:0] fifo_mem_nxt [VCD_FIFO_DEPTH];
    logic [VCD_FIFO_AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [VCD_FIFO_CW-1:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    // A push into a full FIFO is dropped
    assign do_push = push && (cnt_r != VCD_FIFO_CW'(VCD_FIFO_DEPTH));
    assign do_pop = ofifo_valid && ofifo_ready;
    assign free_cnt = VCD_FIFO_CW'(VCD_FIFO_DEPTH) - cnt_r;

    always_comb begin
        fifo_mem_nxt = fifo_mem_r;
        wptr_nxt = wptr_r;
        rptr_nxt = rptr_r;
        cnt_nxt = cnt_r;
        if (do_push) begin
            fifo_mem_nxt[wptr_r] = hwdata;
            wptr_nxt = wptr_r + {{(VCD_FIFO_AW-1){1'b0}}, 1'b1};
        end
        if (do_pop) begin
            rptr_nxt = rptr_r + {{(VCD_FIFO_AW-1){1'b0}}, 1'b1};
        end
        if (do_push && !do_pop) begin
            cnt_nxt = cnt_r + {{(VCD_FIFO_CW-1){1'b0}}, 1'b1};
        end else if (do_pop && !do_push) begin
            cnt_nxt = cnt_r - {{(VCD_FIFO_CW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < VCD_FIFO_DEPTH; i++) begin
                fifo_mem_r[i] <= VCD_RST_WORD;
            end
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            fifo_mem_r <= fifo_mem_nxt;
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign ofifo_valid = (cnt_r != '0);
    assign ofifo_data = fifo_mem_r[rptr_r];
    assign ofifo_transaction_type = VCD_TT_CVID_WR;

endmodule

/* vcd_pkg.sv */
// Purpose: Shared constants for the video capture decimator.
// Assumes: Byte addresses within a 64 KB register window.
// Notes: Offsets are AHB byte addresses.
package vcd_pkg;

    // ==========================================
    // Register map
    localparam logic [15:0] VCD_OFS_FIFO_STAT = 16'hff04;
    localparam logic [15:0] VCD_OFS_FB0 = 16'hff0c;
    localparam logic [15:0] VCD_OFS_FB1 = 16'hff10;
    localparam logic [15:0] VCD_OFS_START = 16'hff28;
    localparam logic [15:0] VCD_OFS_HMASK = 16'hff2c;
    localparam logic [15:0] VCD_OFS_VMASK = 16'hff30;
    localparam logic [15:0] VCD_OFS_STRIDE = 16'hff34;
    localparam logic [15:0] VCD_OFS_CTRL = 16'hff38;
    localparam logic [15:0] VCD_OFS_WIN_LO = 16'hff40;
    localparam logic [15:0] VCD_OFS_WIN_HI = 16'hff5c;

    // ==========================================
    // Field layout
    localparam int unsigned VCD_HSTART_LSB = 0;
    localparam int unsigned VCD_HSTART_W = 12;
    localparam int unsigned VCD_VSTART_LSB = 16;
    localparam int unsigned VCD_VSTART_W = 9;
    localparam int unsigned VCD_STRIDE_W = 12;
    localparam int unsigned VCD_FB_W = 22;
    localparam int unsigned VCD_CTRL_MODE_LSB = 0;
    localparam int unsigned VCD_CTRL_BUF_BIT = 4;
    localparam int unsigned VCD_CTRL_EN_BIT = 8;
    localparam int unsigned VCD_LINE_W = 10;
    localparam int unsigned VCD_HCNT_W = 13;
    localparam logic [12:0] VCD_H_BIAS = 13'h0002;

    // ==========================================
    // Reset values
    localparam logic [31:0] VCD_RST_WORD = 32'h0000_0000;

    // ==========================================
    // Port modes
    typedef enum logic [1:0] {
        VCD_MODE_PASS = 2'b00,
        VCD_MODE_V8 = 2'b01,
        VCD_MODE_V16 = 2'b11
    } vcd_mode_e;

    // ==========================================
    // Output FIFO and peripheral port
    localparam logic [2:0] VCD_TT_CVID_WR = 3'b110;
    localparam int unsigned VCD_FIFO_DEPTH = 8;
    localparam int unsigned VCD_FIFO_AW = 3;
    localparam int unsigned VCD_FIFO_CW = 4;

    // ==========================================
    // AHB-Lite
    localparam logic [2:0] VCD_HSIZE_WORD = 3'b010;
    localparam logic VCD_HRESP_OKAY = 1'b0;

endpackage

/* vcd_props.sv */
// Purpose: Port-level checks of the capture decimator.
// Assumes: One AHB master; pixel clock period of eight hclk cycles.
// Notes: Bound into every vcd_top.
`timescale 1ns/1ps
module vcd_props
    import vcd_pkg::*;
(
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Capture and FIFO
    input wire logic cap_valid,
    input wire logic [2:0] cap_nbytes,
    input wire logic ofifo_valid,
    input wire logic ofifo_ready,
    input wire logic [31:0] ofifo_data,
    input wire logic [2:0] ofifo_transaction_type
);
    // ==========================================
    // Sequences
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic in_win;
    assign in_win = haddr[15:0] >= VCD_OFS_WIN_LO && haddr[15:0] <= VCD_OFS_WIN_HI;
    sequence s_take;
        hsel && hready && htrans[1];
    endsequence
    sequence s_win_wr;
        s_take ##0 (hwrite && in_win && hsize == VCD_HSIZE_WORD && !ofifo_valid);
    endsequence
    sequence s_rd_zero;
        s_take ##0 (!hwrite && (in_win || haddr[15:0] == 16'h0000));
    endsequence
    // ==========================================
    // Properties
    AST_READY: assert property (hreadyout)
        else $error("slave not ready");
    AST_RESP: assert property (hresp == VCD_HRESP_OKAY)
        else $error("slave response not okay");
    AST_WIN_PUSH: assert property (s_win_wr |=> ##1 ofifo_valid)
        else $error("window write did not push");
    AST_RD_ZERO: assert property (s_rd_zero |=> hrdata == 32'h0000_0000)
        else $error("window or unmapped read not zero");
    AST_FIFO_HOLD: assert property (ofifo_valid && !ofifo_ready |=> ofifo_valid && $stable(ofifo_data))
        else $error("fifo head lost while stalled");
    AST_TT: assert property (ofifo_transaction_type == VCD_TT_CVID_WR)
        else $error("wrong transaction type");
    AST_CAP_GAP: assert property (cap_valid |=> !cap_valid [*6])
        else $error("more than one unit per pixel clock");
    AST_NBYTES: assert property (cap_valid |-> cap_nbytes inside {3'h1, 3'h2, 3'h4})
        else $error("bad unit size");
endmodule

bind vcd_top vcd_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cap_valid(cap_valid), .cap_nbytes(cap_nbytes),
    .ofifo_valid(ofifo_valid), .ofifo_ready(ofifo_ready), .ofifo_data(ofifo_data),
    .ofifo_transaction_type(ofifo_transaction_type));

/* vcd_vsrc.sv */
// Purpose: Behavioural video source on the pixel port.
// Assumes: 80 ns pixel clock; syncs and data change mid-low.
// Notes: Clock stands low between frames; word holds line and clock numbers.
`timescale 1ns/1ps
module vcd_vsrc (
    // Control
    input wire logic go,
    input wire logic [7:0] n_lines,
    input wire logic [7:0] n_clks,
    // Pixel port
    output logic pclk = 1'b0,
    output logic hsync = 1'b0,
    output logic vsync = 1'b0,
    output logic [31:0] data = 32'h0000_0000,
    output logic busy = 1'b0
);
    // ==========================================
    // One pixel clock
    task automatic tick(input logic hs, input logic vs, input logic [31:0] d);
        #20;
        hsync = hs;
        vsync = vs;
        data = d;
        #20;
        pclk = 1'b1;
        #40;
        pclk = 1'b0;
    endtask
    // Frame sync clock, lines, closing line sync clock
    always @(posedge go) begin
        #3;
        busy = 1'b1;
        tick(1'b0, 1'b1, ~data);
        for (int l = 1; l <= n_lines; l++) begin
            for (int c = 0; c < n_clks; c++) begin
                tick(c == 0, 1'b0, {2{l[7:0], c[7:0]}});
            end
        end
        tick(1'b1, 1'b0, ~data);
        busy = 1'b0;
    end
endmodule

/* vcd_top_bench.sv */
// Purpose: Self-checking bench of the capture decimator.
// Assumes: Zero wait-state slave; bench is the only bus master.
// Notes: Captures are queued and compared after each frame.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module vcd_top_bench
    import vcd_pkg::*;
;
    localparam logic [21:0] FB0 = 22'h01_0000;
    localparam logic [21:0] FB1 = 22'h02_0000;
    localparam logic [11:0] STRIDE = 12'h140;
    logic hclk, hreadyout, hresp, cap_valid, ofifo_valid, pclk, hsync, vsync, busy;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ofifo_ready = 1'b0, go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hrdata_q, rd, vid_data, cap_data, ofifo_data;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = VCD_HSIZE_WORD, cap_nbytes, tt;
    logic [21:0] cap_addr;
    logic [7:0] n_lines = 8'h00, n_clks = 8'h00;
    logic [56:0] capq[$];
    int mismatches = 0, n_tests = 0, cyc = 0;
    wire logic hready = hreadyout;

    vcd_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_pixel_clock(pclk),
        .vid_hsync(hsync), .vid_vsync(vsync), .vid_data(vid_data), .cap_valid(cap_valid),
        .cap_addr(cap_addr), .cap_data(cap_data), .cap_nbytes(cap_nbytes),
        .ofifo_valid(ofifo_valid), .ofifo_ready(ofifo_ready), .ofifo_data(ofifo_data),
        .ofifo_transaction_type(tt));
    vcd_vsrc i_src (.go(go), .n_lines(n_lines), .n_clks(n_clks), .pclk(pclk), .hsync(hsync),
        .vsync(vsync), .data(vid_data), .busy(busy));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Read data sampled at the closing edge, capture log and hang limit
    always @(posedge hclk) begin
        hrdata_q <= hrdata;
        cyc <= cyc + 1;
        if (cap_valid === 1'b1) capq.push_back({cap_addr, cap_data, cap_nbytes});
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    // ==========================================
    // Bus and reporting
    task automatic ahb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {16'h0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        #1;
        d = hrdata_q;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regs();
        logic [15:0] a[5] = '{VCD_OFS_START, VCD_OFS_HMASK, VCD_OFS_VMASK, VCD_OFS_STRIDE, 16'h0};
        logic [31:0] v[5] = '{32'h01a5_0abc, 32'h5a5a_c3c3, 32'hffff_0001, 32'h0f38, 32'hffff_ffff};
        ahb(1'b0, VCD_OFS_VMASK, 32'h0, rd);
        `CHK("line mask reset", 32'h0, rd)
        for (int i = 0; i < 5; i++) begin
            ahb(1'b1, a[i], v[i], rd);
            ahb(1'b0, a[i], 32'h0, rd);
            `CHK("register readback", (i == 4) ? 32'h0 : v[i], rd)
        end
    endtask
    task automatic t_fifo();
        ahb(1'b0, VCD_OFS_FIFO_STAT, 32'h0, rd);
        `CHK("free count", 32'h8, rd & 32'hf)
        for (int i = 0; i < 8; i++) ahb(1'b1, VCD_OFS_WIN_LO + 16'(4 * i), 32'hc0de_0000 + i, rd);
        ahb(1'b1, VCD_OFS_WIN_HI, 32'hdead_beef, rd);
        ahb(1'b0, VCD_OFS_FIFO_STAT, 32'h0, rd);
        `CHK("free count full", 32'h0, rd & 32'hf)
        ahb(1'b0, VCD_OFS_WIN_LO, 32'h0, rd);
        `CHK("window read", 32'h0, rd)
        @(posedge hclk);
        ofifo_ready <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge hclk);
            `CHK("fifo head", {1'b1, 3'b110, 32'hc0de_0000 + i}, {ofifo_valid, tt, ofifo_data})
            @(posedge hclk);
        end
        ofifo_ready <= 1'b0;
        @(negedge hclk);
        `CHK("fifo empty", 1'b0, ofifo_valid)
    endtask
    task automatic run_frame(input vcd_mode_e md, input logic [11:0] hs, input logic [8:0] vs,
        input logic [31:0] hm, input logic [31:0] vm, input logic bsel, input logic en,
        input int nl, nc);
        int nb, skip, k, idx;
        logic [21:0] ls, off;
        logic [31:0] ctl;
        nb = (md == VCD_MODE_V8) ? 1 : (md == VCD_MODE_V16) ? 2 : 4;
        skip = (md == VCD_MODE_PASS) ? 1 : hs + 2;
        ctl = {22'h0, bsel, 7'h0, md} << 0;
        ctl[VCD_CTRL_BUF_BIT] = bsel;
        ctl[VCD_CTRL_EN_BIT] = en;
        ahb(1'b1, VCD_OFS_START, {7'h00, vs, 4'h0, hs}, rd);
        ahb(1'b1, VCD_OFS_HMASK, hm, rd);
        ahb(1'b1, VCD_OFS_VMASK, vm, rd);
        ahb(1'b1, VCD_OFS_STRIDE, {20'h0, STRIDE}, rd);
        ahb(1'b1, VCD_OFS_FB0, {10'h0, FB0}, rd);
        ahb(1'b1, VCD_OFS_FB1, {10'h0, FB1}, rd);
        ahb(1'b1, VCD_OFS_CTRL, {ctl[31:2], 2'(md)}, rd);
        capq.delete();
        @(posedge hclk);
        n_lines <= 8'(nl);
        n_clks <= 8'(nc);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        while (busy) @(posedge hclk);
        repeat (8) @(posedge hclk);
        ls = bsel ? FB1 : FB0;
        k = 0;
        for (int l = 1; l <= nl; l++) begin
            off = 22'h0;
            for (int c = skip; c < nc; c++) begin
                idx = (c - skip) % 32;
                if (en && vm[(l - 1) % 32] && (md == VCD_MODE_PASS || l > vs) && !hm[idx]) begin
                    `CHK("capture", {ls + off, {2{l[7:0], c[7:0]}}, 3'(nb)}, capq[k])
                    k++;
                    off = off + 22'(nb);
                end
            end
            ls = ls + 22'(STRIDE);
        end
        `CHK("capture count", k, capq.size())
    endtask
    task automatic t_video8();
        run_frame(VCD_MODE_V8, 12'h003, 9'h001, 32'h0000_0006, 32'h0000_000d, 1'b0, 1'b1, 4, 40);
    endtask
    task automatic t_video16();
        run_frame(VCD_MODE_V16, 12'h000, 9'h000, 32'h8000_0001, 32'hffff_ffff, 1'b1, 1'b1, 3, 36);
    endtask
    task automatic t_pass();
        run_frame(VCD_MODE_PASS, 12'h005, 9'h002, 32'h0000_0010, 32'hffff_ffff, 1'b0, 1'b1, 2, 34);
    endtask
    task automatic t_off();
        run_frame(VCD_MODE_V8, 12'h000, 9'h000, 32'h0000_0000, 32'hffff_ffff, 1'b0, 1'b0, 2, 8);
    endtask

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_fifo();
        t_video8();
        t_video16();
        t_pass();
        t_off();
        conclude();
    end
endmodule
